// ==== logic/crf_pkg.sv ====
// shared constants and types of the core register file
package crf_pkg;
  localparam int INSTR_W = 14;
  localparam int DATA_W = 8;
  localparam int PC_W = 13;
  localparam int PCH_W = 5;
  localparam int STACK_DEPTH = 8;
  localparam int GP_COUNT = 36;
  localparam int BRANCH_CYCLES = 2;

  // register map, bank 0 then bank 1
  localparam logic [7:0] ADDR_INDIRECT_WINDOW = 8'h00;
  localparam logic [7:0] ADDR_TIMER_COUNT = 8'h01;
  localparam logic [7:0] ADDR_PCL = 8'h02;
  localparam logic [7:0] ADDR_FLAGS = 8'h03;
  localparam logic [7:0] ADDR_POINTER = 8'h04;
  localparam logic [7:0] ADDR_PORT_A = 8'h05;
  localparam logic [7:0] ADDR_PORT_B = 8'h06;
  localparam logic [7:0] ADDR_NV_DATA = 8'h08;
  localparam logic [7:0] ADDR_NV_ADDR = 8'h09;
  localparam logic [7:0] ADDR_PCH_BUF = 8'h0A;
  localparam logic [7:0] ADDR_IRQ = 8'h0B;
  localparam logic [7:0] ADDR_INDIRECT_WINDOW_MIRROR = 8'h80;
  localparam logic [7:0] ADDR_OPTION = 8'h81;
  localparam logic [7:0] ADDR_PCL_MIRROR = 8'h82;
  localparam logic [7:0] ADDR_FLAGS_MIRROR = 8'h83;
  localparam logic [7:0] ADDR_POINTER_MIRROR = 8'h84;
  localparam logic [7:0] ADDR_DIR_A = 8'h85;
  localparam logic [7:0] ADDR_DIR_B = 8'h86;
  localparam logic [7:0] ADDR_NV_CTL1 = 8'h88;
  localparam logic [7:0] ADDR_NV_CTL2 = 8'h89;
  localparam logic [6:0] ADDR_GP_FIRST = 7'h0C;
  localparam logic [6:0] ADDR_GP_LAST = ADDR_GP_FIRST + 7'(GP_COUNT - 1);

  // reset values
  localparam logic [7:0] RST_FLAGS_POR = 8'h18;
  localparam logic [7:0] RST_OPTION = 8'hFF;
  localparam logic [4:0] RST_DIR_A = 5'h1F;
  localparam logic [7:0] RST_DIR_B = 8'hFF;
  localparam logic [4:0] RST_PCH_BUF = 5'h00;
  localparam logic [7:0] RST_PCL = 8'h00;

  // field positions and control codes
  localparam int FLAG_C = 0;
  localparam int FLAG_DC = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_SLEEP = 3;
  localparam int FLAG_WDT = 4;
  localparam int FLAG_RP0 = 5;
  localparam int OPT_PSA = 3;
  localparam int IRQ_GATE = 7;
  localparam int NVCTL_WR = 1;
  localparam int NVCTL_WRERR = 3;
  localparam int INS_DEST = 7;
  localparam logic [7:0] CODE_RETURN = 8'h08;
  localparam logic [7:0] CODE_RETFIE = 8'h09;

  typedef enum logic [1:0] {
    CLS_BYTE = 2'h0,
    CLS_BIT = 2'h1,
    CLS_JUMP = 2'h2,
    CLS_LIT = 2'h3
  } crf_class_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_EXEC = 3'h2,
    ST_FILL = 3'h4
  } crf_state_t;

  typedef struct packed {
    crf_class_t cls;
    logic [5:0] opcode;
    logic [6:0] fileAddr;
    logic destFile;
    logic [2:0] bitPos;
    logic [7:0] lit8;
    logic [10:0] lit11;
    logic needsAlu;
    logic writesW;
    logic writesFile;
    logic isGoto;
    logic isCall;
    logic isReturn;
    logic isRetfie;
    logic isRetlw;
  } crf_decode_t;
endpackage

// ==== logic/crf_operand_decode.sv ====
// splits a 14-bit instruction word into its operand fields
`timescale 1ns/100ps
module crf_operand_decode (
  input wire logic [13:0] instrWord,
  output crf_pkg::crf_decode_t decodeOut
);
  logic control;

  always_comb begin
    decodeOut = '0;
    decodeOut.cls = crf_pkg::crf_class_t'(instrWord[13:12]);
    decodeOut.opcode = instrWord[13:8];
    decodeOut.fileAddr = instrWord[6:0];
    decodeOut.destFile = instrWord[crf_pkg::INS_DEST];
    decodeOut.bitPos = instrWord[9:7];
    decodeOut.lit8 = instrWord[7:0];
    decodeOut.lit11 = instrWord[10:0];
    control = (instrWord[13:8] == 6'h00) && !instrWord[crf_pkg::INS_DEST];
    case (decodeOut.cls)
      crf_pkg::CLS_BYTE: begin
        decodeOut.needsAlu = !control;
        decodeOut.writesFile = instrWord[crf_pkg::INS_DEST];
        decodeOut.writesW = !control && !instrWord[crf_pkg::INS_DEST];
        decodeOut.isReturn = control && (instrWord[7:0] == crf_pkg::CODE_RETURN);
        decodeOut.isRetfie = control && (instrWord[7:0] == crf_pkg::CODE_RETFIE);
      end
      crf_pkg::CLS_BIT: begin
        decodeOut.needsAlu = 1'b1;
        decodeOut.writesFile = !instrWord[11];
      end
      crf_pkg::CLS_JUMP: begin
        decodeOut.isGoto = instrWord[11];
        decodeOut.isCall = !instrWord[11];
      end
      default: begin
        decodeOut.isRetlw = (instrWord[11:10] == 2'h1);
        decodeOut.needsAlu = (instrWord[11:10] != 2'h1);
        decodeOut.writesW = (instrWord[11:10] != 2'h1);
      end
    endcase
  end
endmodule

// ==== logic/crf_core_regfile.sv ====
// core register file: banked map, general bytes, pc, stack, operand path
// What this block does
// - each instruction is one 14-bit word: opcode then operand fields
// - byte op result goes to accumulator when select bit 0, else file
// - file address field selects location 0x00..0x7F in current bank
// - bit position field picks which bit of addressed byte is used
// - literal field is eight or eleven bits, per instruction
// - ignored instruction bits may be 0 or 1; generators should use 0
// - indirect window uses pointer as address and has no storage
// - upper five pc bits hidden; buffer copies in, never back
// - watchdog expiry and sleep entry flags survive external pin reset
// - pin and watchdog resets load other-reset values, not power-on ones
// - unimplemented bits and locations read as zero
// - return address stack is eight levels in hardware
// - instructions take one cycle, branches take two; here alu ops take two or more, three if they skip or write pcl
// - thirty-six general purpose bytes besides special registers
// - all locations, accumulator and operand path are eight bits
// - writing timer count clears prescaler when assigned to timer
// - port read-modify-write uses pin levels, not output latch
`timescale 1ns/100ps
module crf_core_regfile #(
  parameter int STACK_DEPTH = crf_pkg::STACK_DEPTH,
  parameter int GP_COUNT = crf_pkg::GP_COUNT
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [13:0] instrWord,
  input wire logic instrValid,
  output logic instrReady,
  input wire logic [7:0] resultData,
  input wire logic resultValid,
  input wire logic skipTaken,
  input wire logic [2:0] flagWe,
  input wire logic [2:0] flagIn,
  input wire logic timerTick,
  input wire logic sleepEnter,
  input wire logic wdtClear,
  input wire logic wdtReset,
  input wire logic extResetPinN,
  input wire logic [4:0] portAPins,
  input wire logic [7:0] portBPins,
  output crf_pkg::crf_decode_t decodeOut,
  output logic [7:0] operandData,
  output logic [7:0] bitMask,
  output logic [7:0] workReg,
  output logic [12:0] progCounter,
  output logic [7:0] coreFlags,
  output logic [7:0] timerCount,
  output logic prescalerClear,
  output logic [7:0] optionBits,
  output logic [7:0] irqBits,
  output logic [4:0] portALatch,
  output logic [7:0] portBLatch,
  output logic [4:0] portADir,
  output logic [7:0] portBDir,
  output logic [7:0] nvDataByte,
  output logic [7:0] nvAddrByte,
  output logic [4:0] nvCtlBits
);
  localparam int SP_W = $clog2(STACK_DEPTH);

  typedef struct packed {
    crf_pkg::crf_state_t st;
    crf_pkg::crf_decode_t dec;
    logic [7:0] effAddr;
    logic [7:0] operand;
    logic [7:0] bitMask;
    logic [7:0] wReg;
    logic [12:0] pc;
    logic [4:0] pchBuf;
    logic [7:0] flags;
    logic [7:0] pointer;
    logic [7:0] timer;
    logic [7:0] irq;
    logic [7:0] option;
    logic [7:0] nvData;
    logic [7:0] nvAddr;
    logic [4:0] nvCtl;
    logic [4:0] latchA;
    logic [4:0] dirA;
    logic [7:0] latchB;
    logic [7:0] dirB;
    logic [SP_W-1:0] sp;
    logic [STACK_DEPTH-1:0][12:0] stack;
    logic [GP_COUNT-1:0][7:0] gp;
    logic [4:0] pinA1;
    logic [4:0] pinA2;
    logic [7:0] pinB1;
    logic [7:0] pinB2;
    logic extRst1;
    logic extRst2;
    logic ready;
    logic prescClr;
  } crf_core_state_t;

  crf_core_state_t s_reg;
  crf_core_state_t s_next;
  crf_pkg::crf_decode_t dec;
  logic [7:0] effAddr;
  logic [1:0] rstSync_reg;
  logic rstn;

  ////////////////////////////////////////////////////////////////////////
  // reset release and decode

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rstSync_reg <= 2'h0;
    end else begin
      rstSync_reg <= {rstSync_reg[0], 1'b1};
    end
  end
  assign rstn = rstSync_reg[1];

  crf_operand_decode u_decode (
    .instrWord(instrWord),
    .decodeOut(dec)
  );

  assign effAddr = (dec.fileAddr == 7'h00) ? s_reg.pointer :
    {s_reg.flags[crf_pkg::FLAG_RP0], dec.fileAddr};

  ////////////////////////////////////////////////////////////////////////
  // register map access

  function automatic logic [7:0] readReg(input crf_core_state_t s, input logic [7:0] a);
    logic [6:0] idx;
    idx = a[6:0] - crf_pkg::ADDR_GP_FIRST;
    readReg = 8'h00;
    if (a[6:0] >= crf_pkg::ADDR_GP_FIRST && a[6:0] <= crf_pkg::ADDR_GP_LAST) begin
      readReg = s.gp[idx[5:0]];
    end else begin
      case (a)
        crf_pkg::ADDR_TIMER_COUNT: readReg = s.timer;
        crf_pkg::ADDR_PCL, crf_pkg::ADDR_PCL_MIRROR: readReg = s.pc[7:0];
        crf_pkg::ADDR_FLAGS, crf_pkg::ADDR_FLAGS_MIRROR: readReg = s.flags;
        crf_pkg::ADDR_POINTER, crf_pkg::ADDR_POINTER_MIRROR: readReg = s.pointer;
        crf_pkg::ADDR_PORT_A: readReg = {3'h0, s.pinA2};
        crf_pkg::ADDR_PORT_B: readReg = s.pinB2;
        crf_pkg::ADDR_NV_DATA: readReg = s.nvData;
        crf_pkg::ADDR_NV_ADDR: readReg = s.nvAddr;
        crf_pkg::ADDR_PCH_BUF, 8'h8A: readReg = {3'h0, s.pchBuf};
        crf_pkg::ADDR_IRQ, 8'h8B: readReg = s.irq;
        crf_pkg::ADDR_OPTION: readReg = s.option;
        crf_pkg::ADDR_DIR_A: readReg = {3'h0, s.dirA};
        crf_pkg::ADDR_DIR_B: readReg = s.dirB;
        crf_pkg::ADDR_NV_CTL1: readReg = {3'h0, s.nvCtl};
        default: readReg = 8'h00;
      endcase
    end
  endfunction

  function automatic crf_core_state_t writeReg(input crf_core_state_t s, input logic [7:0] a,
                                               input logic [7:0] d);
    logic [6:0] idx;
    idx = a[6:0] - crf_pkg::ADDR_GP_FIRST;
    writeReg = s;
    if (a[6:0] >= crf_pkg::ADDR_GP_FIRST && a[6:0] <= crf_pkg::ADDR_GP_LAST) begin
      writeReg.gp[idx[5:0]] = d;
    end else begin
      case (a)
        crf_pkg::ADDR_TIMER_COUNT: begin
          writeReg.timer = d;
          writeReg.prescClr = !s.option[crf_pkg::OPT_PSA];
        end
        crf_pkg::ADDR_PCL, crf_pkg::ADDR_PCL_MIRROR: writeReg.pc = {s.pchBuf, d};
        // sleep and watchdog flags are not software writable
        crf_pkg::ADDR_FLAGS, crf_pkg::ADDR_FLAGS_MIRROR:
          writeReg.flags = {d[7:5], s.flags[4:3], d[2:0]};
        crf_pkg::ADDR_POINTER, crf_pkg::ADDR_POINTER_MIRROR: writeReg.pointer = d;
        crf_pkg::ADDR_PORT_A: writeReg.latchA = d[4:0];
        crf_pkg::ADDR_PORT_B: writeReg.latchB = d;
        crf_pkg::ADDR_NV_DATA: writeReg.nvData = d;
        crf_pkg::ADDR_NV_ADDR: writeReg.nvAddr = d;
        crf_pkg::ADDR_PCH_BUF, 8'h8A: writeReg.pchBuf = d[4:0];
        crf_pkg::ADDR_IRQ, 8'h8B: writeReg.irq = d;
        crf_pkg::ADDR_OPTION: writeReg.option = d;
        crf_pkg::ADDR_DIR_A: writeReg.dirA = d[4:0];
        crf_pkg::ADDR_DIR_B: writeReg.dirB = d;
        crf_pkg::ADDR_NV_CTL1: writeReg.nvCtl = d[4:0];
        default: writeReg = s;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    s_next = s_reg;
    s_next.prescClr = 1'b0;
    s_next.pinA1 = portAPins;
    s_next.pinA2 = s_reg.pinA1;
    s_next.pinB1 = portBPins;
    s_next.pinB2 = s_reg.pinB1;
    s_next.extRst1 = extResetPinN;
    s_next.extRst2 = s_reg.extRst1;
    if (timerTick) begin
      s_next.timer = s_reg.timer + 8'h01;
    end
    if (wdtClear) begin
      s_next.flags[crf_pkg::FLAG_WDT] = 1'b1;
      s_next.flags[crf_pkg::FLAG_SLEEP] = 1'b1;
    end
    if (sleepEnter) begin
      s_next.flags[crf_pkg::FLAG_WDT] = 1'b1;
      s_next.flags[crf_pkg::FLAG_SLEEP] = 1'b0;
    end
    if (!s_reg.extRst2 || wdtReset) begin
      s_next.st = crf_pkg::ST_IDLE;
      s_next.ready = 1'b0;
      s_next.pc = {crf_pkg::RST_PCH_BUF, crf_pkg::RST_PCL};
      s_next.pchBuf = crf_pkg::RST_PCH_BUF;
      s_next.flags = {3'h0, s_reg.flags[4:0]};
      if (wdtReset) begin
        s_next.flags[crf_pkg::FLAG_WDT] = 1'b0;
      end
      s_next.irq = {7'h00, s_reg.irq[0]};
      s_next.option = crf_pkg::RST_OPTION;
      s_next.dirA = crf_pkg::RST_DIR_A;
      s_next.dirB = crf_pkg::RST_DIR_B;
      // an interrupted nonvolatile write is reported
      s_next.nvCtl = 5'h00;
      s_next.nvCtl[crf_pkg::NVCTL_WRERR] = s_reg.nvCtl[crf_pkg::NVCTL_WR];
    end else begin
      case (s_reg.st)
        crf_pkg::ST_IDLE: begin
          if (instrValid && s_reg.ready) begin
            s_next.dec = dec;
            s_next.effAddr = effAddr;
            s_next.operand = readReg(s_reg, effAddr);
            s_next.bitMask = 8'h01 << dec.bitPos;
            if (dec.needsAlu) begin
              s_next.st = crf_pkg::ST_EXEC;
            end else if (dec.isGoto || dec.isCall) begin
              if (dec.isCall) begin
                s_next.stack[s_reg.sp] = s_reg.pc + 13'h0001;
                s_next.sp = s_reg.sp + 1'b1;
              end
              s_next.pc = {s_reg.pchBuf[4:3], dec.lit11};
              s_next.st = crf_pkg::ST_FILL;
            end else if (dec.isReturn || dec.isRetfie || dec.isRetlw) begin
              s_next.sp = s_reg.sp - 1'b1;
              s_next.pc = s_reg.stack[s_reg.sp - 1'b1];
              if (dec.isRetlw) begin
                s_next.wReg = dec.lit8;
              end
              if (dec.isRetfie) begin
                s_next.irq[crf_pkg::IRQ_GATE] = 1'b1;
              end
              s_next.st = crf_pkg::ST_FILL;
            end else begin
              s_next.pc = s_reg.pc + 13'h0001;
            end
          end
        end
        crf_pkg::ST_EXEC: begin
          if (resultValid) begin
            s_next.pc = s_reg.pc + (skipTaken ? 13'h0002 : 13'h0001);
            if (s_reg.dec.writesW) begin
              s_next.wReg = resultData;
            end
            if (s_reg.dec.writesFile) begin
              s_next = writeReg(s_next, s_reg.effAddr, resultData);
            end
            for (int i = 0; i < 3; i++) begin
              if (flagWe[i]) begin
                s_next.flags[i] = flagIn[i];
              end
            end
            if (skipTaken || (s_reg.dec.writesFile && s_reg.effAddr[6:0] ==
                crf_pkg::ADDR_PCL[6:0])) begin
              s_next.st = crf_pkg::ST_FILL;
            end else begin
              s_next.st = crf_pkg::ST_IDLE;
            end
          end
        end
        crf_pkg::ST_FILL: s_next.st = crf_pkg::ST_IDLE;
        default: s_next.st = crf_pkg::ST_IDLE;
      endcase
      s_next.ready = (s_next.st == crf_pkg::ST_IDLE);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_reg <= '0;
      s_reg.st <= crf_pkg::ST_IDLE;
      s_reg.flags <= crf_pkg::RST_FLAGS_POR;
      s_reg.option <= crf_pkg::RST_OPTION;
      s_reg.dirA <= crf_pkg::RST_DIR_A;
      s_reg.dirB <= crf_pkg::RST_DIR_B;
      s_reg.extRst1 <= 1'b1;
      s_reg.extRst2 <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign instrReady = s_reg.ready;
  assign decodeOut = s_reg.dec;
  assign operandData = s_reg.operand;
  assign bitMask = s_reg.bitMask;
  assign workReg = s_reg.wReg;
  assign progCounter = s_reg.pc;
  assign coreFlags = s_reg.flags;
  assign timerCount = s_reg.timer;
  assign prescalerClear = s_reg.prescClr;
  assign optionBits = s_reg.option;
  assign irqBits = s_reg.irq;
  assign portALatch = s_reg.latchA;
  assign portBLatch = s_reg.latchB;
  assign portADir = s_reg.dirA;
  assign portBDir = s_reg.dirB;
  assign nvDataByte = s_reg.nvData;
  assign nvAddrByte = s_reg.nvAddr;
  assign nvCtlBits = s_reg.nvCtl;

  ////////////////////////////////////////////////////////////////////////
  // checks

  logic takeIdle;
  logic finish;
  assign takeIdle = s_reg.ready && instrValid && s_reg.extRst2 && !wdtReset;
  assign finish = s_reg.st == crf_pkg::ST_EXEC && resultValid && s_reg.extRst2 && !wdtReset;

  sequence s_fill;
    (!instrReady && s_reg.st == crf_pkg::ST_FILL) ##1 instrReady;
  endsequence

  property p_dest_w;
    @(posedge clk) disable iff (!rstn)
      finish && s_reg.dec.writesW |=> workReg == $past(resultData);
  endproperty
  a_dest_w: assert property (p_dest_w) else $error("accumulator missed result");

  property p_direct;
    @(posedge clk) disable iff (!rstn)
      takeIdle && dec.fileAddr != 7'h00 |=>
        s_reg.effAddr == {$past(coreFlags[crf_pkg::FLAG_RP0]), $past(dec.fileAddr)};
  endproperty
  a_direct: assert property (p_direct) else $error("direct address wrong");

  property p_indirect;
    @(posedge clk) disable iff (!rstn)
      takeIdle && dec.fileAddr == 7'h00 |=> s_reg.effAddr == $past(s_reg.pointer);
  endproperty
  a_indirect: assert property (p_indirect) else $error("indirect address wrong");

  property p_bitsel;
    @(posedge clk) disable iff (!rstn)
      takeIdle |=> bitMask == (8'h01 << $past(dec.bitPos));
  endproperty
  a_bitsel: assert property (p_bitsel) else $error("bit mask wrong");

  property p_pch_hidden;
    @(posedge clk) disable iff (!rstn)
      finish && s_reg.dec.writesFile && s_reg.effAddr[6:0] == crf_pkg::ADDR_PCH_BUF[6:0] &&
        progCounter[7:1] != 7'h7F |=> progCounter[12:8] == $past(progCounter[12:8]);
  endproperty
  a_pch_hidden: assert property (p_pch_hidden) else $error("pc high changed");

  property p_pin_reset_flags;
    @(posedge clk) disable iff (!rstn)
      !s_reg.extRst2 && !wdtReset && !wdtClear && !sleepEnter |=> $stable(coreFlags[4:3]);
  endproperty
  a_pin_reset_flags: assert property (p_pin_reset_flags) else $error("flags lost");

  property p_unmapped;
    @(posedge clk) disable iff (!rstn)
      takeIdle && effAddr[6:0] == 7'h07 |=> operandData == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("hole not zero");

  property p_branch;
    @(posedge clk) disable iff (!rstn)
      takeIdle && (dec.isGoto || dec.isCall) |=>
        progCounter == {$past(s_reg.pchBuf[4:3]), $past(dec.lit11)} ##0 s_fill;
  endproperty
  a_branch: assert property (p_branch) else $error("branch timing wrong");

  property p_presc;
    @(posedge clk) disable iff (!rstn)
      finish && s_reg.dec.writesFile && s_reg.effAddr == crf_pkg::ADDR_TIMER_COUNT &&
        !optionBits[crf_pkg::OPT_PSA] |=> prescalerClear ##1 !prescalerClear;
  endproperty
  a_presc: assert property (p_presc) else $error("prescaler not cleared");

  property p_port_pins;
    @(posedge clk) disable iff (!rstn)
      takeIdle && effAddr == crf_pkg::ADDR_PORT_B |=> operandData == $past(s_reg.pinB2);
  endproperty
  a_port_pins: assert property (p_port_pins) else $error("port read not pins");
endmodule

// ==== tb/crf_core_regfile_bench.sv ====
// self-checking bench for the core register file
`timescale 1ns/100ps
module crf_core_regfile_bench;
  typedef struct {
    logic [13:0] w;
    logic [7:0] d;
    logic [7:0] op;
    logic [7:0] wr;
    logic c;
  } crf_row_t;
  logic clk, resetn, instrValid, resultValid, skipTaken, timerTick;
  logic sleepEnter, wdtClear, wdtReset, extResetPinN, instrReady, prescalerClear, rdyMid;
  logic [13:0] instrWord;
  logic [2:0] flagWe, flagIn;
  logic [4:0] portAPins, portALatch, portADir, nvCtlBits;
  logic [7:0] resultData, portBPins, operandData, bitMask, workReg, coreFlags, timerCount;
  logic [7:0] optionBits, irqBits, portBLatch, portBDir, nvDataByte, nvAddrByte;
  logic [12:0] progCounter;
  crf_pkg::crf_decode_t decodeOut;
  int err_total, n_tests;
  // literal with x bits set, store, add both ways, bit set, reads
  crf_row_t rows[8] = '{
    '{14'h3320, 8'h20, 8'h00, 8'h20, 1'b0},
    '{14'h00A0, 8'h20, 8'h00, 8'h20, 1'b0},
    '{14'h0720, 8'h5A, 8'h20, 8'h5A, 1'b1},
    '{14'h07A0, 8'h3C, 8'h20, 8'h5A, 1'b1},
    '{14'h1420, 8'h3D, 8'h3C, 8'h5A, 1'b1},
    '{14'h0820, 8'h3D, 8'h3D, 8'h3D, 1'b1},
    '{14'h0807, 8'h00, 8'h00, 8'h00, 1'b1},
    '{14'h0806, 8'hA5, 8'hA5, 8'hA5, 1'b1}};

  crf_core_regfile dut_u (.clk, .resetn, .instrWord, .instrValid, .instrReady, .resultData,
    .resultValid, .skipTaken, .flagWe, .flagIn, .timerTick, .sleepEnter, .wdtClear, .wdtReset,
    .extResetPinN, .portAPins, .portBPins, .decodeOut, .operandData, .bitMask, .workReg,
    .progCounter, .coreFlags, .timerCount, .prescalerClear, .optionBits, .irqBits, .portALatch,
    .portBLatch, .portADir, .portBDir, .nvDataByte, .nvAddrByte, .nvCtlBits);

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic summarize();
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(string nm, logic [12:0] exp, logic [12:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  // result is always offered; the block ignores it outside an alu op
  task automatic run(logic [13:0] w, logic [7:0] d);
    int i;
    i = 0;
    while (instrReady !== 1'b1 && i < 50) begin
      @(negedge clk);
      i++;
    end
    if (i == 50) begin
      err_total++;
      summarize();
    end
    @(posedge clk);
    instrValid <= 1'b1;
    instrWord <= w;
    @(posedge clk);
    instrValid <= 1'b0;
    resultValid <= 1'b1;
    resultData <= d;
    @(negedge clk);
    rdyMid = instrReady;
    @(posedge clk);
    resultValid <= 1'b0;
    @(negedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    resetn = 1'b0;
    {instrValid, resultValid, skipTaken, timerTick, sleepEnter, wdtClear, wdtReset} = '0;
    extResetPinN = 1'b1;
    instrWord = 14'h0000;
    resultData = 8'h00;
    {flagWe, flagIn} = 6'h00;
    portAPins = 5'h15;
    portBPins = 8'hA5;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    @(negedge clk);
    chk("flags", 8'h18, coreFlags);
    chk("option", 8'hFF, optionBits);
    chk("dirA", 5'h1F, portADir);
    chk("dirB", 8'hFF, portBDir);
    foreach (rows[i]) begin
      run(rows[i].w, rows[i].d);
      chk("fileAddr", rows[i].w[6:0], decodeOut.fileAddr);
      chk("dest", rows[i].w[7], decodeOut.destFile);
      chk("lit8", rows[i].w[7:0], decodeOut.lit8);
      chk("work", rows[i].wr, workReg);
      if (rows[i].c) chk("operand", rows[i].op, operandData);
      if (rows[i].w[13:12] == 2'b01) chk("mask", 8'h01 << rows[i].w[9:7], bitMask);
    end
    chk("pc", 13'h0008, progCounter);
    run(14'h3020, 8'h20);
    run(14'h0084, 8'h20);
    run(14'h0800, 8'h3D);
    chk("indirect", 8'h3D, operandData);
    run(14'h1683, coreFlags | 8'h20);
    chk("bank", 1'b1, coreFlags[5]);
    run(14'h0820, 8'h3D);
    chk("mirror", 8'h3D, operandData);
    run(14'h3000, 8'h00);
    run(14'h0081, 8'h00);
    chk("optionW", 8'h00, optionBits);
    run(14'h1283, coreFlags & 8'hDF);
    run(14'h0081, 8'h77);
    chk("presc", 1'b1, prescalerClear);
    chk("timer", 8'h77, timerCount);
    run(14'h0086, 8'h3C);
    run(14'h0806, 8'h00);
    chk("pinRead", 8'hA5, operandData);
    chk("latchB", 8'h3C, portBLatch);
    run(14'h0885, 8'hEA);
    chk("pinA", 8'h15, operandData);
    chk("latchA", 5'h0A, portALatch);
    run(14'h0088, 8'h5C);
    chk("nvData", 8'h5C, nvDataByte);
    run(14'h008A, 8'h08);
    run(14'h2923, 8'h00);
    chk("goto", 13'h0923, progCounter);
    chk("fill", 1'b0, rdyMid);
    run(14'h2050, 8'h00);
    chk("call", 13'h0850, progCounter);
    run(14'h3455, 8'h00);
    chk("retlw", 13'h0924, progCounter);
    chk("retW", 8'h55, workReg);
    run(14'h0082, 8'h40);
    chk("pcl", 13'h0840, progCounter);
    @(posedge clk);
    sleepEnter <= 1'b1;
    @(posedge clk);
    sleepEnter <= 1'b0;
    extResetPinN <= 1'b0;
    repeat (4) @(posedge clk);
    extResetPinN <= 1'b1;
    repeat (4) @(negedge clk);
    chk("pinKeep", 2'b10, coreFlags[4:3]);
    chk("pinBank", 1'b0, coreFlags[5]);
    chk("pinOption", 8'hFF, optionBits);
    chk("pinPc", 13'h0000, progCounter);
    @(posedge clk);
    wdtClear <= 1'b1;
    @(posedge clk);
    wdtClear <= 1'b0;
    wdtReset <= 1'b1;
    @(posedge clk);
    wdtReset <= 1'b0;
    repeat (2) @(negedge clk);
    chk("wdtFlags", 2'b01, coreFlags[4:3]);
    summarize();
  end
endmodule
